// ### rtl/bcid_datapath.sv
// Execution datapath top for the byte cpu instruction set
`timescale 1ns/10ps
// How it works
// - Load accumulator from any source, one cycle
// - Register from direct two, else one cycle
// - Direct from accumulator one, else two cycles
// - Indirect from direct two, else one cycle
// - Load 16-bit data pointer in two cycles
// - Table read at A plus pointer, two cycles
// - Bump PC, read A plus PC, two
// - External moves by pointer address, two cycles
// - Push: raise stack pointer, store, two cycles
// - Pop: store, lower stack pointer, two cycles
// - Exchange whole accumulator byte, one cycle
// - Digit exchange swaps low nibbles only
// - Nibble swap within accumulator, one cycle
// - Add operand into accumulator, one cycle
// - Add with carry into accumulator, one
// - Subtract with borrow from accumulator, one
// - Increment one cycle, pointer increment two
// - Decrement any byte location, one cycle
// - Multiply A by B, four cycles
// - Divide A by B, four cycles
// - Decimal adjust with six and hex 60
// - AND forms one cycle, direct-immediate two
// - OR into accumulator, one cycle
module bcid_datapath (
   input  wire logic                  i_clk,          // System clock
   input  wire logic                  i_sys_rst,      // Synchronous reset
   input  wire logic                  i_issue,        // Operation offered
   input  wire bcid_pkg::bcid_op_type  i_op,           // Operation
   input  wire bcid_pkg::bcid_loc_type i_src,          // Source kind
   input  wire logic [7:0]            i_opnd,         // Source byte
   input  wire logic [7:0]            i_dst_data,     // Destination byte
   input  wire logic [15:0]           i_imm16,        // 16-bit immediate
   input  wire logic [15:0]           i_pc,           // Program counter
   input  wire logic [7:0]            i_ri,           // Pointer register
   input  wire logic [7:0]            i_code_rdata,   // Code read data
   input  wire logic [7:0]            i_xram_rdata,   // External read data
   output logic                       o_ready,        // Can take issue
   output logic                       o_done,         // Operation retired
   output logic [7:0]                 o_acc,          // Accumulator
   output logic [7:0]                 o_b,            // B register
   output logic                       o_carry_flag,   // Carry
   output logic                       o_auxiliary_carry_flag, // Aux carry
   output logic                       o_ovf_flag,     // Overflow
   output logic [15:0]                o_data_pointer_register, // Pointer
   output logic [7:0]                 o_sp,           // Stack pointer
   output logic                       o_mem_we,       // Byte write strobe
   output bcid_pkg::bcid_loc_type     o_mem_kind,     // Write location kind
   output logic [7:0]                 o_mem_addr,     // Stack address
   output logic [7:0]                 o_mem_wdata,    // Write data
   output logic                       o_code_re,      // Code read strobe
   output logic [15:0]                o_code_addr,    // Code address
   output logic                       o_xram_re,      // External read
   output logic                       o_xram_we,      // External write
   output logic [15:0]                o_xram_addr,    // External address
   output logic [7:0]                 o_xram_wdata    // External data
);
   import bcid_pkg::*;

   // ****************************************
   // Issue bookkeeping
   // ****************************************
   logic         busy;       // Multi-cycle op in progress
   logic [2:0]   cnt;        // Cycles left
   bcid_op_type  op_q;       // Latched operation
   bcid_loc_type src_q;      // Latched source kind
   logic [7:0]   opnd_q;     // Latched source byte
   logic [7:0]   dst_q;      // Latched destination byte
   logic [15:0]  imm_q;      // Latched immediate
   bcid_op_type  cur_op;     // Operation in flight
   bcid_loc_type cur_src;    // Source in flight
   logic [7:0]   cur_opnd;   // Raw operand in flight
   logic [7:0]   cur_dst;    // Destination byte in flight
   logic [7:0]   eff;        // Operand, accumulator if named
   logic [2:0]   ncyc;       // Cycles of offered op
   logic         start;      // Op accepted this cycle
   logic         fin;        // Last cycle of an op
   logic [15:0]  acc_ext;    // Accumulator widened

   bcid_alu_if   alu_bus ();

   assign start = i_issue && !busy;
   assign ncyc = cycles_of(i_op, i_src);
   assign cur_op = busy ? op_q : i_op;
   assign cur_src = busy ? src_q : i_src;
   assign cur_opnd = busy ? opnd_q : i_opnd;
   assign cur_dst = busy ? dst_q : i_dst_data;
   assign eff = (cur_src == LOC_ACC) ? o_acc : cur_opnd;
   assign acc_ext = {8'h00, o_acc};
   assign fin = (start && ncyc == CYC_ONE) || (busy && cnt == CYC_ONE);

   // Arithmetic unit hookup
   assign alu_bus.op = cur_op;
   assign alu_bus.a = o_acc;
   assign alu_bus.opnd = eff;
   assign alu_bus.dst = cur_dst;
   assign alu_bus.b = o_b;
   assign alu_bus.cy_in = o_carry_flag;
   assign alu_bus.ac_in = o_auxiliary_carry_flag;

   bcid_alu u_alu (
      .u (alu_bus.alu)
   );

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         busy <= 1'b0;
         cnt <= 3'h0;
      end else if (start && ncyc != CYC_ONE) begin
         busy <= 1'b1;
         cnt <= ncyc - CYC_ONE;
      end else if (busy) begin
         cnt <= cnt - CYC_ONE;
         busy <= (cnt != CYC_ONE);
      end
   end

   // Operand capture at issue
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         op_q <= OP_NOP;
         src_q <= LOC_ACC;
         opnd_q <= 8'h00;
         dst_q <= 8'h00;
         imm_q <= 16'h0000;
      end else if (start) begin
         op_q <= i_op;
         src_q <= i_src;
         opnd_q <= i_opnd;
         dst_q <= i_dst_data;
         imm_q <= i_imm16;
      end
   end

   // Ready and retire strobes
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_ready <= 1'b1;
         o_done <= 1'b0;
      end else begin
         o_ready <= !((start && ncyc != CYC_ONE) || (busy && cnt != CYC_ONE));
         o_done <= fin;
      end
   end

   // ****************************************
   // Accumulator and B register
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_acc <= ACC_RESET;
      end else if (fin) begin
         case (cur_op)
            OP_MOV_A:   o_acc <= eff;
            OP_MOVC_DP, OP_MOVC_PC: o_acc <= i_code_rdata;
            OP_MOVX_RD: o_acc <= i_xram_rdata;
            OP_XCH:     o_acc <= eff;
            OP_XCHD, OP_SWAP: o_acc <= alu_bus.res;
            OP_ADD, OP_ADDC, OP_SUBB: o_acc <= alu_bus.res;
            OP_INC, OP_DEC: begin
               if (cur_src == LOC_ACC) begin
                  o_acc <= alu_bus.res;
               end
            end
            OP_MUL, OP_DIV, OP_DA: o_acc <= alu_bus.res;
            OP_ANL_A, OP_ORL_A: o_acc <= alu_bus.res;
            default: o_acc <= o_acc;
         endcase
      end
   end

   // B register load and high results
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_b <= ACC_RESET;
      end else if (fin) begin
         case (cur_op)
            OP_MOV_B: o_b <= eff;
            OP_MUL, OP_DIV: o_b <= alu_bus.res_b;
            default: o_b <= o_b;
         endcase
      end
   end

   // ****************************************
   // Flags
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_carry_flag <= 1'b0;
         o_auxiliary_carry_flag <= 1'b0;
         o_ovf_flag <= 1'b0;
      end else if (fin) begin
         case (cur_op)
            OP_ADD, OP_ADDC, OP_SUBB: begin
               o_carry_flag <= alu_bus.cy;
               o_auxiliary_carry_flag <= alu_bus.ac;
               o_ovf_flag <= alu_bus.ov;
            end
            OP_DA: o_carry_flag <= alu_bus.cy;
            OP_MUL, OP_DIV: begin
               o_carry_flag <= alu_bus.cy;
               o_ovf_flag <= alu_bus.ov;
            end
            // Logic and moves keep flags
            default: o_carry_flag <= o_carry_flag;
         endcase
      end
   end

   // ****************************************
   // Pointers
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_data_pointer_register <= DATA_POINTER_REGISTER_RESET;
      end else if (fin) begin
         if (cur_op == OP_MOV_DP) begin
            o_data_pointer_register <= imm_q;
         end else if (cur_op == OP_INC_DP) begin
            o_data_pointer_register <= o_data_pointer_register + 16'h0001;
         end
      end
   end

   // Stack pointer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_sp <= SP_RESET;
      end else if (start && i_op == OP_PUSH) begin
         o_sp <= o_sp + 8'h01;
      end else if (fin && cur_op == OP_POP) begin
         o_sp <= o_sp - 8'h01;
      end
   end

   // ****************************************
   // Internal byte writes
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_mem_we <= 1'b0;
         o_mem_kind <= LOC_ACC;
         o_mem_addr <= 8'h00;
         o_mem_wdata <= 8'h00;
      end else begin
         o_mem_we <= 1'b0;
         o_mem_addr <= o_sp;
         if (fin) begin
            case (cur_op)
               OP_MOV_R, OP_MOV_D, OP_MOV_I: begin
                  o_mem_we <= 1'b1;
                  o_mem_kind <= (cur_op == OP_MOV_R) ? LOC_REG :
                                (cur_op == OP_MOV_D) ? LOC_DIR : LOC_IND;
                  o_mem_wdata <= eff;
               end
               OP_PUSH: begin
                  o_mem_we <= 1'b1;
                  o_mem_kind <= LOC_STK;
                  o_mem_wdata <= cur_opnd;
               end
               OP_POP: begin
                  o_mem_we <= 1'b1;
                  o_mem_kind <= LOC_DIR;
                  o_mem_wdata <= cur_opnd;
               end
               OP_XCH: begin
                  o_mem_we <= (cur_src != LOC_ACC);
                  o_mem_kind <= cur_src;
                  o_mem_wdata <= o_acc;
               end
               OP_XCHD: begin
                  o_mem_we <= 1'b1;
                  o_mem_kind <= LOC_IND;
                  o_mem_wdata <= alu_bus.res_b;
               end
               OP_INC, OP_DEC: begin
                  o_mem_we <= (cur_src != LOC_ACC);
                  o_mem_kind <= cur_src;
                  o_mem_wdata <= alu_bus.res;
               end
               OP_ANL_D: begin
                  o_mem_we <= 1'b1;
                  o_mem_kind <= LOC_DIR;
                  o_mem_wdata <= alu_bus.res;
               end
               default: o_mem_we <= 1'b0;
            endcase
         end
      end
   end

   // ****************************************
   // Code and external memory requests
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_code_re <= 1'b0;
         o_code_addr <= 16'h0000;
      end else begin
         o_code_re <= start && (i_op == OP_MOVC_DP || i_op == OP_MOVC_PC);
         if (start && i_op == OP_MOVC_DP) begin
            o_code_addr <= o_data_pointer_register + acc_ext;
         end else if (start && i_op == OP_MOVC_PC) begin
            o_code_addr <= i_pc + 16'h0001 + acc_ext;
         end
      end
   end

   // external request, pointer or data pointer
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_xram_re <= 1'b0;
         o_xram_we <= 1'b0;
         o_xram_addr <= 16'h0000;
         o_xram_wdata <= 8'h00;
      end else begin
         o_xram_re <= start && i_op == OP_MOVX_RD;
         o_xram_we <= start && i_op == OP_MOVX_WR;
         if (start && (i_op == OP_MOVX_RD || i_op == OP_MOVX_WR)) begin
            o_xram_addr <= (i_src == LOC_IND) ? {8'h00, i_ri}
                                              : o_data_pointer_register;
            o_xram_wdata <= o_acc;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   a_load_acc_one: assert property (start && i_op == OP_MOV_A && i_src != LOC_ACC
      |=> o_done && o_acc == $past(i_opnd)) else $error("acc load wrong");
   a_reg_from_dir: assert property (start && i_op == OP_MOV_R && i_src == LOC_DIR
      |=> !o_done && !o_ready ##1 o_done && o_mem_we) else $error("reg load timing");
   a_dir_from_acc: assert property (start && i_op == OP_MOV_D && i_src == LOC_ACC
      |=> o_mem_we && o_mem_wdata == $past(o_acc)) else $error("direct store wrong");
   a_ind_from_dir: assert property (start && i_op == OP_MOV_I && i_src == LOC_DIR
      |=> !o_mem_we ##1 o_mem_we && o_mem_kind == LOC_IND) else $error("indirect timing");
   a_data_pointer_register_load: assert property (start && i_op == OP_MOV_DP
      |=> ##1 o_data_pointer_register == $past(i_imm16, 2)) else $error("pointer load");
   a_table_addr: assert property (start && i_op == OP_MOVC_DP
      |=> o_code_re && o_code_addr == $past(o_data_pointer_register) + $past(acc_ext))
      else $error("table address");
   a_push_order: assert property (start && i_op == OP_PUSH
      |=> o_sp == $past(o_sp) + 8'h01 ##1 o_mem_we && o_mem_addr == o_sp)
      else $error("push order");
   a_pop_order: assert property (start && i_op == OP_POP
      |=> ##1 o_mem_we && o_sp == $past(o_sp, 2) - 8'h01
      && o_mem_wdata == $past(i_opnd, 2)) else $error("pop order");
   a_nibble_swap: assert property (start && i_op == OP_SWAP
      |=> o_acc == {$past(o_acc[3:0]), $past(o_acc[7:4])}) else $error("swap wrong");
   a_add_sum: assert property (start && i_op == OP_ADD
      |=> o_acc == $past(o_acc) + $past(eff)) else $error("add wrong");
   a_mul_four: assert property (start && i_op == OP_MUL
      |=> !o_ready [*3] ##1 o_done && {o_b, o_acc} == $past(o_acc, 4) * $past(o_b, 4))
      else $error("multiply wrong");
   a_logic_carry: assert property (start && (i_op == OP_ANL_A || i_op == OP_ORL_A)
      |=> o_carry_flag == $past(o_carry_flag)) else $error("logic touched carry");

   c_divide: cover property (start && i_op == OP_DIV ##4 o_done);
   c_movx_read: cover property (start && i_op == OP_MOVX_RD ##2 o_done);
   c_da_carry: cover property (start && i_op == OP_DA ##1 o_carry_flag);
endmodule : bcid_datapath

// ### rtl/bcid_pkg.sv
// Shared types and constants of the byte cpu instruction datapath
package bcid_pkg;
   // ****************************************
   // Operation and operand encodings
   // ****************************************
   typedef enum logic [4:0] {
      OP_NOP     = 5'h00, OP_MOV_A   = 5'h01, OP_MOV_R   = 5'h02,
      OP_MOV_D   = 5'h03, OP_MOV_I   = 5'h04, OP_MOV_DP  = 5'h05,
      OP_MOVC_DP = 5'h06, OP_MOVC_PC = 5'h07, OP_MOVX_RD = 5'h08,
      OP_MOVX_WR = 5'h09, OP_PUSH    = 5'h0a, OP_POP     = 5'h0b,
      OP_XCH     = 5'h0c, OP_XCHD    = 5'h0d, OP_SWAP    = 5'h0e,
      OP_ADD     = 5'h0f, OP_ADDC    = 5'h10, OP_SUBB    = 5'h11,
      OP_INC     = 5'h12, OP_INC_DP  = 5'h13, OP_DEC     = 5'h14,
      OP_MUL     = 5'h15, OP_DIV     = 5'h16, OP_DA      = 5'h17,
      OP_ANL_A   = 5'h18, OP_ANL_D   = 5'h19, OP_ORL_A   = 5'h1a,
      OP_MOV_B   = 5'h1b
   } bcid_op_type;
   // Source or destination location kind
   typedef enum logic [2:0] {
      LOC_ACC = 3'h0, LOC_REG = 3'h1, LOC_DIR = 3'h2,
      LOC_IND = 3'h3, LOC_IMM = 3'h4, LOC_STK = 3'h5
   } bcid_loc_type;
   // ****************************************
   // Reset values and constants
   // ****************************************
   localparam logic [7:0]  ACC_RESET  = 8'h00;
   localparam logic [7:0]  SP_RESET   = 8'h07;
   localparam logic [15:0] DATA_POINTER_REGISTER_RESET = 16'h0000;
   localparam logic [7:0]  DA_LOW     = 8'h06;
   localparam logic [7:0]  DA_HIGH    = 8'h60;
   localparam logic [3:0]  DIGIT_MAX  = 4'h9;
   // Cycle counts, one cycle is one clock period of 10 ns
   localparam logic [2:0]  CYC_ONE    = 3'h1;
   localparam logic [2:0]  CYC_TWO    = 3'h2;
   localparam logic [2:0]  CYC_FOUR   = 3'h4;

   // Cycles taken by an operation with a given source
   function automatic logic [2:0] cycles_of(input bcid_op_type op,
                                            input bcid_loc_type src);
      logic [2:0] n;
      n = CYC_ONE;
      case (op)
         OP_MOV_R, OP_MOV_I: n = (src == LOC_DIR) ? CYC_TWO : CYC_ONE;
         OP_MOV_D:           n = (src == LOC_ACC) ? CYC_ONE : CYC_TWO;
         OP_ANL_D:           n = (src == LOC_ACC) ? CYC_ONE : CYC_TWO;
         OP_MOV_DP, OP_MOVC_DP, OP_MOVC_PC, OP_MOVX_RD, OP_MOVX_WR,
         OP_PUSH, OP_POP, OP_INC_DP: n = CYC_TWO;
         OP_MUL, OP_DIV:     n = CYC_FOUR;
         default:            n = CYC_ONE;
      endcase
      return n;
   endfunction : cycles_of
endpackage : bcid_pkg

// ### rtl/bcid_alu_if.sv
// Bundle between the datapath core and its arithmetic unit
`timescale 1ns/10ps
interface bcid_alu_if;
   import bcid_pkg::*;
   bcid_op_type op;     // Operation
   logic [7:0]  a;      // Accumulator
   logic [7:0]  opnd;   // Effective operand
   logic [7:0]  dst;    // Destination byte for read-modify-write
   logic [7:0]  b;      // B register
   logic        cy_in;  // Carry in
   logic        ac_in;  // Auxiliary carry in
   logic [7:0]  res;    // Main result
   logic [7:0]  res_b;  // Second result
   logic        cy;     // Carry out
   logic        ac;     // Auxiliary carry out
   logic        ov;     // Overflow out
   modport core (output op, a, opnd, dst, b, cy_in, ac_in,
                 input res, res_b, cy, ac, ov);
   modport alu  (input op, a, opnd, dst, b, cy_in, ac_in,
                 output res, res_b, cy, ac, ov);
endinterface : bcid_alu_if

// ### rtl/bcid_alu.sv
// Combinational arithmetic and logic unit of the datapath
`timescale 1ns/10ps
module bcid_alu (
   bcid_alu_if.alu u
);
   import bcid_pkg::*;
   logic [8:0]  sum9;   // Byte sum with carry
   logic [4:0]  nib5;   // Low nibble sum
   logic [15:0] prod;   // Product
   logic [8:0]  da9;    // Decimal adjust step
   logic        da_c;   // Decimal adjust carry

   // Result selection by operation
   always_comb begin
      sum9 = 9'h000;
      nib5 = 5'h00;
      prod = 16'h0000;
      da9 = 9'h000;
      da_c = u.cy_in;
      u.res = u.opnd;
      u.res_b = u.b;
      u.cy = u.cy_in;
      u.ac = u.ac_in;
      u.ov = 1'b0;
      case (u.op)
         OP_ADD, OP_ADDC: begin
            sum9 = {1'b0, u.a} + {1'b0, u.opnd} + {8'h00, u.op == OP_ADDC && u.cy_in};
            nib5 = {1'b0, u.a[3:0]} + {1'b0, u.opnd[3:0]}
                 + {4'h0, u.op == OP_ADDC && u.cy_in};
            u.res = sum9[7:0];
            u.cy = sum9[8];
            u.ac = nib5[4];
            u.ov = (u.a[7] == u.opnd[7]) && (sum9[7] != u.a[7]);
         end
         OP_SUBB: begin
            sum9 = {1'b0, u.a} - {1'b0, u.opnd} - {8'h00, u.cy_in};
            nib5 = {1'b0, u.a[3:0]} - {1'b0, u.opnd[3:0]} - {4'h0, u.cy_in};
            u.res = sum9[7:0];
            u.cy = sum9[8];
            u.ac = nib5[4];
            u.ov = (u.a[7] != u.opnd[7]) && (sum9[7] != u.a[7]);
         end
         OP_INC:   u.res = u.opnd + 8'h01;
         OP_DEC:   u.res = u.opnd - 8'h01;
         OP_ANL_A: u.res = u.a & u.opnd;
         OP_ANL_D: u.res = u.dst & u.opnd;
         OP_ORL_A: u.res = u.a | u.opnd;
         OP_SWAP:  u.res = {u.a[3:0], u.a[7:4]};
         OP_XCHD: begin
            u.res = {u.a[7:4], u.opnd[3:0]};
            u.res_b = {u.opnd[7:4], u.a[3:0]};
         end
         OP_MUL: begin
            prod = {8'h00, u.a} * {8'h00, u.b};
            u.res = prod[7:0];
            u.res_b = prod[15:8];
            u.cy = 1'b0;
            u.ov = |prod[15:8];
         end
         OP_DIV: begin
            u.cy = 1'b0;
            u.ov = (u.b == 8'h00);
            u.res = u.a;
            if (u.b != 8'h00) begin
               u.res = u.a / u.b;
               u.res_b = u.a % u.b;
            end
         end
         OP_DA: begin
            // Two adjust steps, carry set by either overflow
            da9 = {1'b0, u.a};
            if (da9[3:0] > DIGIT_MAX || u.ac_in) begin
               da9 = {1'b0, da9[7:0]} + {1'b0, DA_LOW};
               da_c = da_c | da9[8];
            end
            if (da9[7:4] > DIGIT_MAX || da_c) begin
               da9 = {1'b0, da9[7:0]} + {1'b0, DA_HIGH};
               da_c = da_c | da9[8];
            end
            u.res = da9[7:0];
            u.cy = da_c;
         end
         default: u.res = u.opnd;
      endcase
   end
endmodule : bcid_alu

// ### testbench/bcid_mem_model.sv
// Code and external data memory model on the far side
`timescale 1ns/10ps
module bcid_mem_model (
   input  wire logic        i_clk,   // System clock
   input  wire logic        i_cre,   // Code read strobe
   input  wire logic [15:0] i_ca,    // Code address
   input  wire logic        i_xre,   // External read strobe
   input  wire logic [15:0] i_xa,    // External address
   output logic      [7:0]  o_cd,    // Code byte
   output logic      [7:0]  o_xd     // External byte
);
   logic [7:0] pat = 8'h11;  // Filler that changes every cycle
   always @(posedge i_clk) pat <= pat + 8'h3b;
   assign o_cd = i_cre ? i_ca[7:0] ^ i_ca[15:8] ^ 8'ha5 : pat;
   assign o_xd = i_xre ? i_xa[7:0] ^ i_xa[15:8] ^ 8'ha5 : ~pat;
endmodule : bcid_mem_model

// ### testbench/tb_byte_cpu_instruction_datapath.sv
// Self-checking bench of the byte cpu instruction datapath
`timescale 1ns/10ps
module tb_byte_cpu_instruction_datapath;
   import bcid_pkg::*;
   logic i_clk, i_sys_rst, i_issue, o_ready, o_done, o_carry_flag, o_auxiliary_carry_flag;
   logic o_ovf_flag, o_mem_we, o_code_re, o_xram_re, o_xram_we;
   logic [7:0] i_opnd, i_dst_data, i_ri, i_code_rdata, i_xram_rdata, o_acc, o_b, o_sp;
   logic [7:0] o_mem_addr, o_mem_wdata, o_xram_wdata;
   logic [15:0] i_imm16, i_pc, o_data_pointer_register, o_code_addr, o_xram_addr;
   bcid_op_type i_op;
   bcid_loc_type i_src, o_mem_kind;
   int fails, cmp_count, a, b, c, x, v, dp, sp, j;
   bcid_op_type ops[21] = '{OP_MOV_A, OP_MOV_B, OP_ADD, OP_ADDC, OP_SUBB, OP_INC, OP_DEC,
      OP_MUL, OP_DIV, OP_DA, OP_ANL_A, OP_ORL_A, OP_SWAP, OP_XCH, OP_MOV_DP, OP_INC_DP,
      OP_MOVC_DP, OP_MOVC_PC, OP_MOVX_RD, OP_PUSH, OP_POP};
   int ncy[21] = '{1, 1, 1, 1, 1, 1, 1, 4, 4, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2};
   bcid_datapath DUT (.*);
   bcid_mem_model mem (.i_clk, .i_cre(o_code_re), .i_ca(o_code_addr), .i_xre(o_xram_re),
      .i_xa(o_xram_addr), .o_cd(i_code_rdata), .o_xd(i_xram_rdata));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Byte the memory model serves at an address
   function automatic int mf(input int ad);
      return (ad % 256) ^ ((ad / 256) % 256) ^ 165;
   endfunction : mf
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   // Issue one operation, wait for retirement, compare with the model
   task automatic run(input bcid_op_type o, input bcid_loc_type s, input int d, input int n);
      int k, r, t, m, p, ri;
      m = $urandom % 65536;
      p = $urandom % 65536;
      ri = $urandom % 256;
      @(posedge i_clk);
      {i_issue, i_op, i_src, i_opnd, i_imm16, i_pc, i_ri} <= {1'b1, o, s, 8'(d), 16'(m), 16'(p), 8'(ri)};
      i_dst_data <= 8'($urandom);
      @(posedge i_clk);
      i_issue <= 1'b0;
      // Results are registered at the taking edge, so look just after it first
      for (k = 1; k < 9; k++) begin
         #1;
         chk(o_ready, k >= n);
         if (o_done === 1'b1) break;
         @(posedge i_clk);
      end
      if (k == 9) begin
         fails++;
         end_sim();
      end
      t = (o == OP_ADDC) ? c : 0;
      case (o)
         OP_MOV_A, OP_XCH: a = d;
         OP_MOV_B: b = d;
         OP_ADD, OP_ADDC: begin
            r = a + d + t;
            x = (a % 16 + d % 16 + t) > 15;
            v = ((a ^ r) & (d ^ r) & 128) != 0;
            c = r > 255;
            a = r % 256;
         end
         OP_SUBB: begin
            r = a - d - c;
            x = (a % 16 - d % 16 - c) < 0;
            v = ((a ^ d) & (a ^ r) & 128) != 0;
            c = r < 0;
            a = r & 255;
         end
         OP_INC: a = (a + 1) % 256;
         OP_DEC: a = (a + 255) % 256;
         OP_MUL: {c, v, a, b} = {0, int'(a * b > 255), (a * b) % 256, (a * b) / 256};
         OP_DIV: if (b == 0) {c, v} = {0, 1}; else {c, v, a, b} = {0, 0, a / b, a % b};
         OP_DA: begin
            if (a % 16 > 9 || x) {c, a} = {int'(c || a + 6 > 255), (a + 6) % 256};
            if (a / 16 > 9 || c) {c, a} = {int'(c || a + 96 > 255), (a + 96) % 256};
         end
         OP_ANL_A: a = a & d;
         OP_ORL_A: a = a | d;
         OP_SWAP: a = (a % 16) * 16 + a / 16;
         OP_MOV_DP: dp = m;
         OP_INC_DP: dp = (dp + 1) % 65536;
         OP_MOVC_DP: a = mf(a + dp);
         OP_MOVC_PC: a = mf(p + 1 + a);
         OP_MOVX_RD: a = mf(s == LOC_IND ? ri : dp);
         OP_PUSH: begin
            sp = (sp + 1) % 256;
            chk({o_mem_we, o_mem_kind, o_mem_addr, o_mem_wdata}, {1'b1, LOC_STK, 8'(sp), 8'(d)});
         end
         OP_POP: sp = (sp + 255) % 256;
         default: ;
      endcase
      chk(k, n);
      chk({o_acc, o_b, o_carry_flag, o_auxiliary_carry_flag, o_ovf_flag, o_sp},
          {8'(a), 8'(b), 1'(c), 1'(x), 1'(v), 8'(sp)});
      chk(o_data_pointer_register, dp);
   endtask : run
   initial begin
      void'($urandom(32'h17d066e6));
      {i_sys_rst, i_issue, i_op, i_src, i_opnd, i_dst_data, i_imm16, i_pc, i_ri} = {1'b1, 65'h0};
      {a, b, c, x, v, dp, sp} = {0, 0, 0, 0, 0, 0, 7};
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      run(OP_MOV_B, LOC_IMM, 0, 1);
      run(OP_DIV, LOC_ACC, 0, 4);
      for (int q = 0; q < 400; q++) begin
         j = $urandom % 21;
         run(ops[j], (ops[j] inside {OP_INC, OP_DEC}) ? LOC_ACC : bcid_loc_type'(1 + $urandom % 4),
             $urandom % 256, ncy[j]);
      end
      end_sim();
   end
endmodule : tb_byte_cpu_instruction_datapath
